// *** hw/arr_result_regs.sv ***
// monitoring converter result registers with pass sequencer and byte read port
// assumes the serial interface front end delivers byte reads synchronous to clk_i
//
// Functional notes
// - battery current word is 16-bit read-only, resets to zero, field in 15:2, bits 1:0 zero.
// - battery current field is two's complement, charging positive, discharging negative.
// - battery current steps 4mA and clamps to 38ADh..3FFFh low side and 0h..3E8h high side.
// - battery current result is held at zero while the charge enable bit is cleared.
// - battery current is never negative from the input source, never positive on battery.
// - a polarity change during the current conversion aborts it and the word reads 8000h.
// - input voltage word resets to zero, field 14:2, 3.97mV steps, clamps at 11B6h.
// - mid-node voltage word resets to zero, field 14:2, 3.97mV steps, clamps at 11B6h.
// - battery voltage word resets to zero, field 12:1, 1.99mV steps, clamps at AF0h.
// - results power up at zero, then keep the last completed value and never self-clear.
// - with the one-shot setting one pass runs, otherwise passes repeat continuously.
module arr_result_regs
   import arr_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        adc_enable_i,
   input  wire logic                        adc_one_shot_i,
   input  wire logic                        charge_enable_bit_i,
   input  wire logic                        battery_only_i,
   output logic                             conv_req_o,
   output logic             [ARR_CHAN_W-1:0] conv_chan_o,
   input  wire logic                        sample_valid_i,
   input  wire logic signed [ARR_RAW_W-1:0] sample_value_i,
   input  wire logic                        sample_abort_i,
   output logic                             pass_done_o,
   input  wire logic                        rd_stb_i,
   input  wire logic        [ARR_ADDR_W-1:0] rd_addr_i,
   output logic             [7:0]           rd_data_o,
   output logic                             rd_valid_o
);
   arr_regs_type                  r_ff;
   arr_regs_type                  nxt_r;
   logic signed [ARR_RAW_W-1:0]   ibat_raw;
   logic        [ARR_WORD_W-1:0] ibat_word;
   logic        [ARR_WORD_W-1:0] vbus_word;
   logic        [ARR_WORD_W-1:0] vpmid_word;
   logic        [ARR_WORD_W-1:0] vbat_word;
   logic        [ARR_ADDR_W-1:0] word_addr;
   logic        [ARR_WORD_W-1:0] rd_word;
   logic                         rd_hit;
   logic                         store;

   // a sample that contradicts the power source is reported as zero current
   // forcing happens before the clamp, so a forced code is always in range
   always_comb begin
      ibat_raw = sample_value_i;
      if (!battery_only_i && sample_value_i < ARR_RAW_ZERO) begin
         ibat_raw = ARR_RAW_ZERO;
      end else if (battery_only_i && sample_value_i > ARR_RAW_ZERO) begin
         ibat_raw = ARR_RAW_ZERO;
      end
   end

   // two's complement field, sign kept by the clamp limits
   arr_clamp #(
      .FIELD_W (ARR_IBAT_W),
      .LSB     (ARR_IBAT_LSB),
      .MIN     (ARR_IBAT_MIN),
      .MAX     (ARR_IBAT_MAX)
   ) u_clamp_ibat (
      .raw_i   (ibat_raw),
      .word_o  (ibat_word)
   );

   // voltage channels floor at zero, so a negative raw code reads as zero
   arr_clamp #(
      .FIELD_W (ARR_VIN_W),
      .LSB     (ARR_VIN_LSB),
      .MIN     (ARR_VIN_MIN),
      .MAX     (ARR_VIN_MAX)
   ) u_clamp_vbus (
      .raw_i   (sample_value_i),
      .word_o  (vbus_word)
   );

   arr_clamp #(
      .FIELD_W (ARR_VIN_W),
      .LSB     (ARR_VIN_LSB),
      .MIN     (ARR_VIN_MIN),
      .MAX     (ARR_VIN_MAX)
   ) u_clamp_vpmid (
      .raw_i   (sample_value_i),
      .word_o  (vpmid_word)
   );

   arr_clamp #(
      .FIELD_W (ARR_VBAT_W),
      .LSB     (ARR_VBAT_LSB),
      .MIN     (ARR_VBAT_MIN),
      .MAX     (ARR_VBAT_MAX)
   ) u_clamp_vbat (
      .raw_i   (sample_value_i),
      .word_o  (vbat_word)
   );

   // word lookup by the even address of the pair
   // addresses outside the four words read as zero and leave the shadow alone
   always_comb begin
      word_addr = {rd_addr_i[ARR_ADDR_W-1:1], 1'b0};
      rd_hit    = 1'b1;
      case (word_addr)
         ARR_ADDR_IBAT:  rd_word = r_ff.ibat;
         ARR_ADDR_VBUS:  rd_word = r_ff.vbus;
         ARR_ADDR_VPMID: rd_word = r_ff.vpmid;
         ARR_ADDR_VBAT:  rd_word = r_ff.vbat;
         default: begin
            rd_word = ARR_WORD_ZERO;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // a sample offered outside a conversion or with the enable low is dropped
   assign store = (r_ff.state == ARR_CONV) && adc_enable_i && sample_valid_i;

   always_comb begin
      nxt_r           = r_ff;
      nxt_r.pass_done = 1'b0;
      nxt_r.rd_valid  = 1'b0;

      // pass sequencer
      case (r_ff.state)
         ARR_IDLE: begin
            if (adc_enable_i) begin
               nxt_r.state = ARR_CONV;
               nxt_r.chan  = ARR_CH_IBAT;
            end
         end
         ARR_CONV: begin
            if (!adc_enable_i) begin
               // results already stored are kept
               nxt_r.state = ARR_IDLE;
            end else if (sample_valid_i) begin
               nxt_r.chan = r_ff.chan + 2'h1;
               if (r_ff.chan == ARR_CH_LAST) begin
                  nxt_r.pass_done = 1'b1;
                  nxt_r.chan      = ARR_CH_IBAT;
                  if (adc_one_shot_i) begin
                     nxt_r.state = ARR_HOLD;
                  end
               end
            end
         end
         ARR_HOLD: begin
            // one pass done; a new one needs the enable to drop and return
            if (!adc_enable_i) begin
               nxt_r.state = ARR_IDLE;
            end
         end
         default: begin
            nxt_r.state = ARR_IDLE;
         end
      endcase

      // results change only on a completed sample, except ibat, which the cleared charge enable bit forces to zero
      if (store) begin
         case (r_ff.chan)
            ARR_CH_IBAT: begin
               if (sample_abort_i) begin
                  nxt_r.ibat = ARR_WORD_ABORT;
               end else begin
                  nxt_r.ibat = ibat_word;
               end
            end
            ARR_CH_VBUS:  nxt_r.vbus  = vbus_word;
            ARR_CH_VPMID: nxt_r.vpmid = vpmid_word;
            default:      nxt_r.vbat  = vbat_word;
         endcase
      end

      // wins over any sample in the same cycle
      // a read in the cycle the bit drops still sees the old word
      if (!charge_enable_bit_i) begin
         nxt_r.ibat = ARR_WORD_ZERO;
      end

      // low byte read captures the high byte so the pair stays coherent
      // limitation: an odd byte read alone returns the last captured high byte
      if (rd_stb_i) begin
         nxt_r.rd_valid = 1'b1;
         if (!rd_hit) begin
            nxt_r.rd_data = ARR_BYTE_ZERO;
         end else if (!rd_addr_i[0]) begin
            nxt_r.rd_data   = rd_word[7:0];
            nxt_r.shadow_hi = rd_word[15:8];
         end else begin
            nxt_r.rd_data = r_ff.shadow_hi;
         end
      end
   end

   // synchronous reset; results return to zero, the sequencer to idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff.state     <= ARR_IDLE;
         r_ff.chan      <= ARR_CH_IBAT;
         r_ff.ibat      <= ARR_WORD_ZERO;
         r_ff.vbus      <= ARR_WORD_ZERO;
         r_ff.vpmid     <= ARR_WORD_ZERO;
         r_ff.vbat      <= ARR_WORD_ZERO;
         r_ff.shadow_hi <= ARR_BYTE_ZERO;
         r_ff.rd_data   <= ARR_BYTE_ZERO;
         r_ff.rd_valid  <= 1'b0;
         r_ff.pass_done <= 1'b0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // request decoded from state so the converter sees it with no extra lag
   assign conv_req_o  = (r_ff.state == ARR_CONV);
   assign conv_chan_o = r_ff.chan;
   assign pass_done_o = r_ff.pass_done;
   assign rd_data_o   = r_ff.rd_data;
   assign rd_valid_o  = r_ff.rd_valid;
endmodule

// *** hw/arr_pkg.sv ***
// constants shared by the monitoring result registers
// assumes one clock domain and byte-wide register reads from the serial interface
package arr_pkg;
   localparam int                 ARR_RAW_W      = 17;
   localparam int                 ARR_WORD_W     = 16;
   localparam int                 ARR_ADDR_W     = 8;
   localparam int                 ARR_CHAN_W     = 2;
   // register byte addresses, low byte at the listed address
   localparam logic [7:0]         ARR_ADDR_IBAT  = 8'h2A;
   localparam logic [7:0]         ARR_ADDR_VBUS  = 8'h2C;
   localparam logic [7:0]         ARR_ADDR_VPMID = 8'h2E;
   localparam logic [7:0]         ARR_ADDR_VBAT  = 8'h30;
   // field positions and widths
   localparam int                 ARR_IBAT_LSB   = 2;
   localparam int                 ARR_IBAT_W     = 14;
   localparam int                 ARR_VIN_LSB    = 2;
   localparam int                 ARR_VIN_W      = 13;
   localparam int                 ARR_VBAT_LSB   = 1;
   localparam int                 ARR_VBAT_W     = 12;
   // clamp limits as signed raw codes; 17'h1F8AD is field code 38ADh
   localparam logic signed [16:0] ARR_IBAT_MIN   = 17'h1F8AD;
   localparam logic signed [16:0] ARR_IBAT_MAX   = 17'h003E8;
   localparam logic signed [16:0] ARR_VIN_MIN    = 17'h00000;
   localparam logic signed [16:0] ARR_VIN_MAX    = 17'h011B6;
   localparam logic signed [16:0] ARR_VBAT_MIN   = 17'h00000;
   localparam logic signed [16:0] ARR_VBAT_MAX   = 17'h00AF0;
   localparam logic signed [16:0] ARR_RAW_ZERO   = 17'h00000;
   // step sizes, for reference by software models
   localparam real                ARR_IBAT_STEP_MA = 4.0;
   localparam real                ARR_VIN_STEP_MV  = 3.97;
   localparam real                ARR_VBAT_STEP_MV = 1.99;
   localparam logic [15:0]        ARR_WORD_ZERO  = 16'h0000;
   localparam logic [15:0]        ARR_WORD_ABORT = 16'h8000;
   localparam logic [7:0]         ARR_BYTE_ZERO  = 8'h00;
   // conversion channel order within one pass
   localparam logic [1:0]         ARR_CH_IBAT    = 2'h0;
   localparam logic [1:0]         ARR_CH_VBUS    = 2'h1;
   localparam logic [1:0]         ARR_CH_VPMID   = 2'h2;
   localparam logic [1:0]         ARR_CH_VBAT    = 2'h3;
   localparam logic [1:0]         ARR_CH_LAST    = 2'h3;

   typedef enum logic [1:0] {
      ARR_IDLE,
      ARR_CONV,
      ARR_HOLD
   } arr_state_type;

   typedef struct packed {
      arr_state_type state;
      logic [1:0]    chan;
      logic [15:0]   ibat;
      logic [15:0]   vbus;
      logic [15:0]   vpmid;
      logic [15:0]   vbat;
      logic [7:0]    shadow_hi;
      logic [7:0]    rd_data;
      logic          rd_valid;
      logic          pass_done;
   } arr_regs_type;
endpackage

// *** hw/arr_clamp.sv ***
// clamps one raw converter code and places it in its register word
// assumes raw codes arrive sign-extended to the raw width
module arr_clamp
   import arr_pkg::*;
#(
   parameter int                  FIELD_W = 12,
   parameter int                  LSB     = 0,
   parameter logic signed [16:0]  MIN     = 17'h00000,
   parameter logic signed [16:0]  MAX     = 17'h00FFF
) (
   input  wire logic signed [ARR_RAW_W-1:0] raw_i,
   output logic             [ARR_WORD_W-1:0] word_o
);
   logic signed [ARR_RAW_W-1:0]  clamped;
   logic        [ARR_WORD_W-1:0] ext;

   always_comb begin
      if (raw_i < MIN) begin
         clamped = MIN;
      end else if (raw_i > MAX) begin
         clamped = MAX;
      end else begin
         clamped = raw_i;
      end
      // unused bits above and below the field stay zero
      ext    = ARR_WORD_W'(clamped[FIELD_W-1:0]);
      word_o = ext << LSB;
   end
endmodule

// *** bench/arr_result_regs_monitor.sv ***
// concurrent checks on the result register ports
// assumes one clock domain, bound to every arr_result_regs instance
module arr_result_regs_monitor
   import arr_pkg::*;
(
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire logic                        adc_enable_i,
   input wire logic                        adc_one_shot_i,
   input wire logic                        charge_enable_bit_i,
   input wire logic                        battery_only_i,
   input wire logic                        conv_req_o,
   input wire logic        [ARR_CHAN_W-1:0] conv_chan_o,
   input wire logic                        sample_valid_i,
   input wire logic signed [ARR_RAW_W-1:0] sample_value_i,
   input wire logic                        sample_abort_i,
   input wire logic                        pass_done_o,
   input wire logic                        rd_stb_i,
   input wire logic        [ARR_ADDR_W-1:0] rd_addr_i,
   input wire logic        [7:0]           rd_data_o,
   input wire logic                        rd_valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic take = conv_req_o && adc_enable_i && sample_valid_i;
   wire logic last = take && conv_chan_o == 2'h3;
   a_rd_answer: assert property (rd_stb_i |=> rd_valid_o)
      else $error("read not answered");
   a_rd_quiet: assert property (!rd_stb_i |=> !rd_valid_o)
      else $error("read valid without request");
   a_unmapped_zero: assert property (rd_stb_i && (rd_addr_i < 8'h2A || rd_addr_i > 8'h31)
      |=> rd_data_o == 8'h00) else $error("unmapped byte not zero");
   a_ibat_low: assert property (rd_stb_i && rd_addr_i == ARR_ADDR_IBAT
      |=> rd_data_o[1:0] == 2'h0) else $error("current low bits set");
   a_vbus_low: assert property (rd_stb_i && rd_addr_i == ARR_ADDR_VBUS
      |=> rd_data_o[1:0] == 2'h0) else $error("input voltage low bits set");
   a_vpmid_low: assert property (rd_stb_i && rd_addr_i == ARR_ADDR_VPMID
      |=> rd_data_o[1:0] == 2'h0) else $error("mid-node low bits set");
   a_vbat_low: assert property (rd_stb_i && rd_addr_i == ARR_ADDR_VBAT
      |=> rd_data_o[0] == 1'b0) else $error("battery voltage bit 0 set");
   a_chg_off: assert property (!charge_enable_bit_i && !$past(charge_enable_bit_i) &&
      rd_stb_i && rd_addr_i == ARR_ADDR_IBAT |=> rd_data_o == 8'h00)
      else $error("current not zero with charging off");
   a_chan_step: assert property (take && conv_chan_o != 2'h3
      |=> conv_chan_o == $past(conv_chan_o) + 2'h1) else $error("channel did not advance");
   a_pass_done: assert property (last |=> pass_done_o)
      else $error("pass end not flagged");
   a_pass_quiet: assert property (!last |=> !pass_done_o)
      else $error("pass end flagged early");
   a_one_shot: assert property (last && adc_one_shot_i |=> !conv_req_o [*2])
      else $error("one shot pass kept converting");
endmodule

bind arr_result_regs arr_result_regs_monitor mon (.*);

// *** bench/arr_conv_model.sv ***
// behavioural converter answering the sequencer's sample requests
// assumes requests are sampled at the rising edge of clk_i
module arr_conv_model (
   input  wire logic              clk_i,
   input  wire logic              req_i,
   input  wire logic [1:0]        chan_i,
   input  wire logic [3:0][16:0]  vals_i,
   input  wire logic              abort_i,
   input  wire logic [1:0]        slow_i,
   output logic                   valid_o,
   output logic signed [16:0]     value_o,
   output logic                   flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_q = 2'h0;
   always @(posedge clk_i) begin
      valid_o <= 1'b0;
      flag_o <= 1'b0;
      // value is only meaningful with valid, so it never lingers
      value_o <= ~value_o;
      if (req_i && !valid_o) begin
         if (wait_q < slow_i) begin
            wait_q <= wait_q + 2'h1;
         end else begin
            wait_q <= 2'h0;
            valid_o <= 1'b1;
            value_o <= vals_i[chan_i];
            flag_o <= abort_i && chan_i == 2'h0;
         end
      end
   end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the result registers
// assumes the converter model and the bound checker are compiled alongside
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import arr_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, adc_enable_i = 1'b0;
   logic adc_one_shot_i = 1'b0, rd_stb_i = 1'b0;
   logic charge_enable_bit_i = 1'b1, battery_only_i = 1'b0, abort_req = 1'b0;
   logic [7:0] rd_addr_i = 8'h00;
   logic [3:0][16:0] vals = '0;
   logic [1:0] slow = 2'h0;
   wire logic conv_req_o, sample_valid_i, sample_abort_i, pass_done_o, rd_valid_o;
   wire logic [1:0] conv_chan_o;
   wire logic signed [16:0] sample_value_i;
   wire logic [7:0] rd_data_o;
   int error_cnt = 0;
   int cmp_count = 0;
   arr_result_regs uut (.clk_i, .rst_i, .adc_enable_i, .adc_one_shot_i, .charge_enable_bit_i,
      .battery_only_i, .conv_req_o, .conv_chan_o, .sample_valid_i, .sample_value_i,
      .sample_abort_i, .pass_done_o, .rd_stb_i, .rd_addr_i, .rd_data_o, .rd_valid_o);
   arr_conv_model conv (.clk_i(clk_i), .req_i(conv_req_o), .chan_i(conv_chan_o), .vals_i(vals),
      .abort_i(abort_req), .slow_i(slow), .valid_o(sample_valid_i),
      .value_o(sample_value_i), .flag_o(sample_abort_i));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // low byte then high byte back to back, high comes from the shadow
   task cw(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] w;
      @(posedge clk_i) begin rd_stb_i <= 1'b1; rd_addr_i <= a; end
      @(posedge clk_i) rd_addr_i <= a + 8'h01;
      #1 w[7:0] = rd_data_o;
      `CHK(rd_valid_o, 1'b1)
      @(posedge clk_i) rd_stb_i <= 1'b0;
      #1 w[15:8] = rd_data_o;
      `CHK(w, e)
   endtask
   task run(input logic signed [16:0] v0, v1, v2, v3, input logic o, b, x, input logic [1:0] s);
      int n;
      @(posedge clk_i) begin vals <= {v3, v2, v1, v0}; adc_one_shot_i <= o; end
      battery_only_i <= b;
      abort_req <= x;
      slow <= s;
      adc_enable_i <= 1'b1;
      n = 0;
      do begin @(posedge clk_i); #1 n++; end while (pass_done_o !== 1'b1 && n < 200);
      `CHK(pass_done_o, 1'b1)
      `CHK(conv_req_o, ~o)
      `CHK(conv_chan_o, ARR_CH_IBAT)
      @(posedge clk_i) adc_enable_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task t_reset;
      cw(ARR_ADDR_IBAT, ARR_WORD_ZERO);
      cw(ARR_ADDR_VBUS, ARR_WORD_ZERO);
      cw(ARR_ADDR_VPMID, ARR_WORD_ZERO);
      cw(ARR_ADDR_VBAT, ARR_WORD_ZERO);
      cw(8'h28, ARR_WORD_ZERO);
      $display("reset test done");
   endtask
   task t_clamp;
      run(17'sd2000, 17'h02000, 17'h00123, 17'h01000, 1'b1, 1'b0, 1'b0, 2'h0);
      cw(ARR_ADDR_IBAT, {ARR_IBAT_MAX[13:0], 2'h0});
      cw(ARR_ADDR_VBUS, {1'b0, ARR_VIN_MAX[12:0], 2'h0});
      cw(ARR_ADDR_VPMID, {1'b0, 13'h0123, 2'h0});
      cw(ARR_ADDR_VBAT, {3'h0, ARR_VBAT_MAX[11:0], 1'b0});
      run(-17'sd3000, 17'h011B6, 17'h011B5, 17'h00AF0, 1'b0, 1'b1, 1'b0, 2'h3);
      cw(ARR_ADDR_IBAT, {ARR_IBAT_MIN[13:0], 2'h0});
      cw(ARR_ADDR_VPMID, {1'b0, 13'h11B5, 2'h0});
      cw(ARR_ADDR_VBAT, {3'h0, 12'hAF0, 1'b0});
      $display("clamp test done");
   endtask
   task t_sign;
      run(-17'sd5, 17'h0, 17'h0, 17'h0, 1'b1, 1'b1, 1'b0, 2'h1);
      cw(ARR_ADDR_IBAT, {14'h3FFB, 2'h0});
      run(17'sd5, 17'h0, 17'h0, 17'h0, 1'b1, 1'b0, 1'b0, 2'h0);
      cw(ARR_ADDR_IBAT, {14'h0005, 2'h0});
      run(-17'sd5, 17'h0, 17'h0, 17'h0, 1'b1, 1'b0, 1'b0, 2'h0);
      cw(ARR_ADDR_IBAT, ARR_WORD_ZERO);
      run(17'sd5, 17'h0, 17'h0, 17'h0, 1'b1, 1'b1, 1'b0, 2'h0);
      cw(ARR_ADDR_IBAT, ARR_WORD_ZERO);
      $display("sign test done");
   endtask
   task t_abort;
      run(17'sd100, 17'h00010, 17'h0, 17'h0, 1'b1, 1'b0, 1'b1, 2'h2);
      cw(ARR_ADDR_IBAT, ARR_WORD_ABORT);
      cw(ARR_ADDR_VBUS, {1'b0, 13'h0010, 2'h0});
      $display("abort test done");
   endtask
   task t_chg;
      run(17'sd7, 17'h00020, 17'h0, 17'h0, 1'b1, 1'b0, 1'b0, 2'h0);
      @(posedge clk_i) charge_enable_bit_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      cw(ARR_ADDR_IBAT, ARR_WORD_ZERO);
      @(posedge clk_i) charge_enable_bit_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      cw(ARR_ADDR_IBAT, ARR_WORD_ZERO);
      cw(ARR_ADDR_VBUS, {1'b0, 13'h0020, 2'h0});
      $display("charge enable test done");
   endtask
   // a second reset must clear a word that already holds data
   task t_rst;
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      cw(ARR_ADDR_VBUS, ARR_WORD_ZERO);
      $display("second reset test done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_clamp;
      t_sign;
      t_abort;
      t_chg;
      t_rst;
      end_sim;
   end
   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      end_sim;
   end
endmodule
